// ===== core/pss_defines.svh
/*
 * timing counts and LED blink divisors for the supply sequencer.
 * assumes a 100 MHz clock; all times reduce to 1 ms ticks.
 */
// Behaviour
// R1: main output off one second after power-good drops
// R2: start/stop by AC or by enable request
// R3: main regulation 5 to 400 ms after enable
// R4: power-good drops within 5 ms of disable
// R5: power-good 100 to 500 ms after regulation
// R6: power-good drops 1 ms before rails leave regulation
// R7: power-good low at least 100 ms per cycle
// R8: power-good held 10 ms after AC loss
// R9: main rail 50 to 1000 ms after standby
// R10: standby regulated within 1500 ms of AC
// R11: all rails regulated within 3000 ms of AC
// R12: alert asserted within 2 ms of AC loss
// R13: hot standby switches off output OR-ing gate
// R14: solid green when on, dark without AC
// R15: 1 Hz green blink for standby or hot standby
// R16: solid yellow when cord pulled, peer powered
// R17: 1 Hz yellow blink for warnings
// R18: solid yellow after critical shutdown
// R19: 2 Hz green blink in firmware upload
// R20: enable request is active low
// R21: toggling enable clears latched faults
// R22: alert low on any shutdown or warning; code drives it low only on faults, warnings and AC loss
// R23: power-good only while all rails regulate
// R24: blink from divided clock, equal halves
// R25: LED priority critical, warning, then others
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ----------------------------------------------------------------
// time base
// ----------------------------------------------------------------
`define PSS_CLK_MHZ        100
`define PSS_TICK_NS        1000000
`define PSS_TICK_CYC       (`PSS_TICK_NS * `PSS_CLK_MHZ / 1000)

// ----------------------------------------------------------------
// sequencing times in ms
// ----------------------------------------------------------------
`define PSS_OFF_MIN_MS     1000
`define PSS_MAIN_ON_MS     20
`define PSS_SB_MAIN_MS     60
`define PSS_PG_ON_MS       150
`define PSS_PG_LOW_MS      100
`define PSS_PG_HOLD_MS     10
`define PSS_PG_LEAD_MS     2
`define PSS_ALERT_MS       2
`define PSS_BLINK1_MS      500
`define PSS_BLINK2_MS      250

`endif

// ===== core/pss_pkg.sv
/*
 * types for the supply sequencer.
 * assumes nothing beyond the defines header.
 */
package pss_pkg;

    typedef enum logic [2:0] {
        PSS_OFF     = 3'b000,
        PSS_SB_UP   = 3'b001,
        PSS_MAIN_UP = 3'b010,
        PSS_PG_WAIT = 3'b011,
        PSS_ON      = 3'b100,
        PSS_PG_DROP = 3'b101,
        PSS_RAIL_DN = 3'b110,
        PSS_REST    = 3'b111
    } pss_state_e;

    typedef enum logic [1:0] {
        PSS_LED_DARK   = 2'b00,
        PSS_LED_GREEN  = 2'b01,
        PSS_LED_YELLOW = 2'b10
    } pss_led_e;

    typedef struct packed {
        logic ac_ok;
        logic standby_ok;
        logic main_ok;
        logic peer_ac;
        logic warning;
        logic critical;
        logic fw_upload;
        logic hot_standby_req;
    } pss_sense_s;

    typedef struct packed {
        logic     standby_rail_en;
        logic     main_rail_en;
        logic     oring_en;
        logic     power_good;
        logic     attention_out_n;
        pss_led_e led;
    } pss_drive_s;

endpackage

// ===== core/pss_sequencer.sv
/*
 * power-up/down sequencer, power-good, alert and status LED.
 * assumes rail status and fault inputs come from analogue sense
 * logic off this clock domain and are synchronised here.
 */
`timescale 1ns/100ps
`include "pss_defines.svh"

module pss_sequencer #(
    parameter int TICK_CYC = `PSS_TICK_CYC
) (
    // clock, reset and enable
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic           clk_en,
    // host and sense pins
    input  wire logic           output_enable_request_n,
    input  wire pss_pkg::pss_sense_s sense,
    // drives
    output pss_pkg::pss_drive_s drive
);
    import pss_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pss_sense_s s1;
        pss_sense_s s2;
        logic       en1;
        logic       en2;
        logic       en_prev;
        pss_state_e st;
        logic [31:0] div;
        logic       tick;
        logic [11:0] ms;
        logic [11:0] rest_ms;
        logic [9:0] blink;
        logic       latched;
        logic       ac_lost;
        logic [3:0] ac_ms;
        pss_drive_s o;
    } pss_reg_s;

    pss_reg_s r;
    pss_reg_s next_r;

    always_comb begin
        logic       en;
        logic       rails_ok;
        logic       fault;
        logic       b1;
        logic       b2;
        pss_sense_s s;
        en = 1'b0;
        rails_ok = 1'b0;
        fault = 1'b0;
        b1 = 1'b0;
        b2 = 1'b0;
        s = '0;
        next_r = r;
        s = r.s2;
        en = r.en2;
        // two-flop synchronisers; first stage feeds only the second
        next_r.s1 = sense;
        next_r.s2 = r.s1;
        next_r.en1 = ~output_enable_request_n;  // R20
        next_r.en2 = r.en1;
        next_r.en_prev = en;

        // ----------------------------------------------------------------
        // millisecond tick and counters
        // ----------------------------------------------------------------
        next_r.tick = 1'b0;
        if (r.div >= 32'(TICK_CYC - 1)) begin
            next_r.div = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.div = r.div + 32'd1;
        end
        if (r.tick) begin
            if (r.ms != 12'hFFF)
                next_r.ms = r.ms + 12'h001;
            if (r.rest_ms != 12'hFFF)
                next_r.rest_ms = r.rest_ms + 12'h001;
            next_r.blink = r.blink + 10'h001;
            if (r.ac_lost && r.ac_ms != 4'hF)
                next_r.ac_ms = r.ac_ms + 4'h1;
        end

        // ----------------------------------------------------------------
        // faults and AC loss
        // ----------------------------------------------------------------
        if (s.critical)
            next_r.latched = 1'b1;
        else if (en != r.en_prev)
            next_r.latched = 1'b0;  // R21
        fault = r.latched | s.critical;
        if (!s.ac_ok) begin
            next_r.ac_lost = 1'b1;
        end else begin
            next_r.ac_lost = 1'b0;
            next_r.ac_ms = '0;
        end
        rails_ok = s.standby_ok & s.main_ok;

        // ----------------------------------------------------------------
        // sequencer
        // ----------------------------------------------------------------
        case (r.st)
        PSS_OFF: begin
            next_r.o.main_rail_en = 1'b0;
            next_r.o.power_good = 1'b0;
            if (s.ac_ok) begin
                next_r.o.standby_rail_en = 1'b1;  // R10
                next_r.st = PSS_SB_UP;
                next_r.ms = '0;
            end
        end
        PSS_SB_UP: begin
            if (!s.ac_ok) begin
                next_r.st = PSS_OFF;
                next_r.o.standby_rail_en = 1'b0;
            end else if (s.standby_ok && en && !fault &&
                         r.rest_ms >= 12'(`PSS_OFF_MIN_MS) &&
                         r.ms >= 12'(`PSS_SB_MAIN_MS)) begin  // R1 R2 R3
                next_r.o.main_rail_en = 1'b1;  // R9 R11
                next_r.st = PSS_MAIN_UP;
                next_r.ms = '0;
            end else if (!(s.standby_ok && en)) begin
                // delay counts from both standby good and enable
                next_r.ms = '0;  // R3 R9
            end
        end
        PSS_MAIN_UP: begin
            if (!en || fault || !s.ac_ok) begin
                next_r.st = PSS_RAIL_DN;
            end else if (rails_ok) begin
                next_r.st = PSS_PG_WAIT;
                next_r.ms = '0;
            end
        end
        PSS_PG_WAIT: begin
            if (!en || fault || !s.ac_ok || !rails_ok) begin
                next_r.st = PSS_RAIL_DN;
            end else if (r.ms >= 12'(`PSS_PG_ON_MS)) begin  // R5
                next_r.o.power_good = 1'b1;
                next_r.st = PSS_ON;
            end
        end
        PSS_ON: begin
            if (!rails_ok || fault) begin
                next_r.o.power_good = 1'b0;  // R23
                next_r.st = PSS_PG_DROP;
                next_r.ms = '0;
            end else if (!en) begin
                next_r.o.power_good = 1'b0;  // R4
                next_r.st = PSS_PG_DROP;
                next_r.ms = '0;
            end else if (r.ac_lost &&
                         r.ac_ms >= 4'(`PSS_PG_HOLD_MS + 1)) begin  // R8
                next_r.o.power_good = 1'b0;
                next_r.st = PSS_PG_DROP;
                next_r.ms = '0;
            end
        end
        PSS_PG_DROP: begin
            // rails stay up until power-good has led them down
            if (r.ms >= 12'(`PSS_PG_LEAD_MS))  // R6
                next_r.st = PSS_RAIL_DN;
        end
        PSS_RAIL_DN: begin
            next_r.o.power_good = 1'b0;
            next_r.o.main_rail_en = 1'b0;
            next_r.rest_ms = '0;
            next_r.st = PSS_REST;
        end
        PSS_REST: begin
            // one second covers the 100 ms power-good low time too
            if (r.rest_ms >= 12'(`PSS_OFF_MIN_MS) &&
                r.rest_ms >= 12'(`PSS_PG_LOW_MS)) begin  // R1 R7
                next_r.st = s.ac_ok ? PSS_SB_UP : PSS_OFF;
                next_r.o.standby_rail_en = s.ac_ok;
                next_r.ms = '0;
            end
        end
        default: next_r.st = PSS_OFF;
        endcase

        // OR-ing gate off whenever hot standby is requested or main is off
        next_r.o.oring_en = next_r.o.main_rail_en &
                            ~s.hot_standby_req;  // R13

        // alert is OR of latched or critical fault, warning and AC-loss
        next_r.o.attention_out_n = ~(fault | s.warning |
                                     ~s.ac_ok);  // R12 R22

        // ----------------------------------------------------------------
        // LED
        // ----------------------------------------------------------------
        b1 = r.blink[9];  // R24
        b2 = r.blink[8];
        if (fault)
            next_r.o.led = PSS_LED_YELLOW;  // R18 R25
        else if (s.warning)
            next_r.o.led = b1 ? PSS_LED_YELLOW : PSS_LED_DARK;  // R17
        else if (!s.ac_ok)
            next_r.o.led = s.peer_ac ? PSS_LED_YELLOW
                                     : PSS_LED_DARK;  // R14 R16
        else if (s.fw_upload)
            next_r.o.led = b2 ? PSS_LED_GREEN : PSS_LED_DARK;  // R19
        else if (r.st == PSS_ON && !s.hot_standby_req)
            next_r.o.led = PSS_LED_GREEN;  // R14
        else
            next_r.o.led = b1 ? PSS_LED_GREEN : PSS_LED_DARK;  // R15
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.rest_ms <= 12'(`PSS_OFF_MIN_MS);
            r.o.attention_out_n <= 1'b1;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign drive = r.o;

endmodule

// ===== verification/pss_seq_asserts.sv
/* checker on the sequencer drives.
   assumes TICK_CYC cycles make one 1 ms tick. */
`timescale 1ns/100ps
module pss_seq_asserts #(
    parameter int TICK_CYC = 10
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                output_enable_request_n,
    input wire pss_pkg::pss_sense_s sense,
    input wire pss_pkg::pss_drive_s drive
);
    localparam int MS = TICK_CYC;
    localparam int A_MAX = 2 * TICK_CYC;
    localparam int D_MAX = 5 * TICK_CYC;
    // saturating counts: pg low, main ok, ac lost
    logic [15:0] lo, ok, lost;
    logic        seen;
    always_ff @(posedge clk) begin
        if (reset) begin
            lo   <= 16'h0;
            ok   <= 16'h0;
            lost <= 16'h0;
            seen <= 1'b0;
        end else begin
            lo   <= drive.power_good ? 16'h0 : lo + 16'(lo != 16'hFFFF);
            ok   <= sense.main_ok ? ok + 16'(ok != 16'hFFFF) : 16'h0;
            lost <= sense.ac_ok ? 16'h0 : lost + 16'(lost != 16'hFFFF);
            seen <= seen | drive.power_good;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    pg_rails_a: assert property (
        drive.power_good |-> drive.main_rail_en && drive.standby_rail_en)
        else $error("power good without rails");
    // depth is 1 ms at the bench tick of 10 cycles
    pg_lead_a: assert property (
        $fell(drive.main_rail_en) |-> $past(drive.power_good, 10) == 1'b0)
        else $error("main dropped too soon");
    alert_ac_a: assert property (
        $fell(sense.ac_ok) && drive.power_good
            |-> ##[1:A_MAX] !drive.attention_out_n)
        else $error("alert late");
    pg_hold_a: assert property (
        $fell(drive.power_good) |-> sense.ac_ok || lost >= 16'(10 * MS))
        else $error("power good hold short");
    pg_low_a: assert property (
        $rose(drive.power_good) |-> lo >= 16'(100 * MS))
        else $error("power good low too short");
    pg_off_a: assert property (
        $rose(output_enable_request_n) && drive.power_good
            |-> ##[1:D_MAX] !drive.power_good)
        else $error("power good late off");
    pg_delay_a: assert property (
        $rose(drive.power_good)
            |-> ok >= 16'(100 * MS) && ok <= 16'(500 * MS))
        else $error("power good delay out of window");
    main_rest_a: assert property (
        $rose(drive.main_rail_en) && seen |-> lo >= 16'(1000 * MS))
        else $error("restart inside rest");
endmodule
bind pss_sequencer pss_seq_asserts #(.TICK_CYC(TICK_CYC)) chk (
    .clk(clk),
    .reset(reset),
    .output_enable_request_n(output_enable_request_n),
    .sense(sense),
    .drive(drive)
);

// ===== verification/pss_host_model.sv
/* host and rail sense model.
   assumes rails settle RISE_CYC cycles after enable. */
`timescale 1ns/100ps
module pss_host_model #(
    parameter int RISE_CYC = 20
) (
    input  wire logic                clk,
    input  wire logic                on_cmd,
    input  wire pss_pkg::pss_drive_s drive,
    output logic                     output_enable_request_n = 1'b1,
    output logic                     standby_ok = 1'b0,
    output logic                     main_ok = 1'b0
);
    int sb = 0;
    int mn = 0;
    // no hold-up: rails fall two cycles after their enable
    always @(posedge clk) begin
        output_enable_request_n <= !on_cmd;
        sb <= drive.standby_rail_en ? sb + 1 : 0;
        mn <= drive.main_rail_en ? mn + 1 : 0;
        standby_ok <= sb >= RISE_CYC;
        main_ok <= mn >= RISE_CYC;
    end
endmodule

// ===== verification/pss_sequencer_test.sv
/* bench for the supply sequencer.
   assumes a tick of 10 cycles and 20 cycle rail settling. */
`timescale 1ns/100ps
module pss_sequencer_test;
    import pss_pkg::*;
    localparam int MS = 10;
    localparam int AT = 2;
    localparam int PG = 3;
    localparam int MN = 5;
    localparam int SB = 6;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       on_cmd = 1'b0;
    logic       en_n, sb_ok, mn_ok;
    pss_sense_s sns = '0;
    pss_sense_s sense;
    pss_drive_s drive;
    int         bad_count = 0;
    int         checked = 0;
    int         n, a;
    always #5 clk = ~clk;
    always_comb begin
        sense = sns;
        sense.standby_ok = sb_ok;
        sense.main_ok = mn_ok;
    end
    pss_sequencer #(.TICK_CYC(MS)) dut (.clk(clk), .reset(reset),
        .clk_en(1'b1), .output_enable_request_n(en_n),
        .sense(sense), .drive(drive));
    pss_host_model host (.clk(clk), .on_cmd(on_cmd), .drive(drive),
        .output_enable_request_n(en_n), .standby_ok(sb_ok),
        .main_ok(mn_ok));
    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic till(input int b, input logic v, input int lim);
        n = 0;
        while (drive[b] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // whole periods only, so the count is phase independent
    task automatic led(input pss_led_e c, input int lim, want);
        int k = 0;
        repeat (lim) begin
            @(negedge clk);
            k += int'(drive.led === c);
        end
        chk("led", 16'(want), 16'(k));
    endtask
    task automatic finish_test;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_standby;
        @(posedge clk);
        sns.ac_ok <= 1'b1;
        till(SB, 1'b1, 1498 * MS);
        chk("standby", 1, drive.standby_rail_en);
        repeat (100) @(negedge clk);
        led(PSS_LED_GREEN, 10240, 5120);
        @(posedge clk);
        sns.fw_upload <= 1'b1;
        repeat (50) @(negedge clk);
        led(PSS_LED_GREEN, 5120, 2560);
        @(posedge clk);
        sns.fw_upload <= 1'b0;
        $display("t_standby done");
    endtask
    task automatic t_on;
        @(posedge clk);
        on_cmd <= 1'b1;
        till(MN, 1'b1, 400 * MS);
        chk("main", 1, n >= 5 * MS && n <= 398 * MS);
        till(PG, 1'b1, 600 * MS);
        chk("pg", 1, n >= 102 * MS && n <= 502 * MS);
        repeat (2) @(negedge clk);
        chk("green", PSS_LED_GREEN, drive.led);
        chk("alert", 1, drive.attention_out_n);
        $display("t_on done");
    endtask
    task automatic t_off;
        @(posedge clk);
        on_cmd <= 1'b0;
        till(PG, 1'b0, 5 * MS);
        chk("pg off", 0, drive.power_good);
        till(MN, 1'b0, 10 * MS);
        chk("lead", 1, n >= MS && !drive.main_rail_en);
        @(posedge clk);
        on_cmd <= 1'b1;
        till(MN, 1'b1, 1100 * MS);
        chk("rest", 1, n >= 998 * MS);
        till(PG, 1'b1, 600 * MS);
        $display("t_off done");
    endtask
    task automatic t_modes;
        @(posedge clk);
        sns.hot_standby_req <= 1'b1;
        repeat (50) @(negedge clk);
        chk("oring", 0, drive.oring_en);
        led(PSS_LED_GREEN, 10240, 5120);
        @(posedge clk);
        sns.hot_standby_req <= 1'b0;
        sns.warning <= 1'b1;
        repeat (50) @(negedge clk);
        chk("warn", 0, drive.attention_out_n);
        chk("oring", 1, drive.oring_en);
        led(PSS_LED_YELLOW, 10240, 5120);
        $display("t_modes done");
    endtask
    task automatic t_crit;
        @(posedge clk);
        sns.critical <= 1'b1;
        till(PG, 1'b0, 5 * MS);
        led(PSS_LED_YELLOW, 10240, 10240);
        chk("crit", 0, drive.attention_out_n);
        @(posedge clk);
        sns.critical <= 1'b0;
        sns.warning <= 1'b0;
        on_cmd <= 1'b0;
        repeat (20 * MS) @(posedge clk);
        on_cmd <= 1'b1;
        till(PG, 1'b1, 1700 * MS);
        chk("cleared", 1, drive.power_good);
        $display("t_crit done");
    endtask
    task automatic t_acloss;
        @(posedge clk);
        sns.peer_ac <= 1'b1;
        sns.ac_ok <= 1'b0;
        till(AT, 1'b0, 2 * MS);
        chk("ac alert", 0, drive.attention_out_n);
        a = n;
        till(PG, 1'b0, 50 * MS);
        chk("hold", 1, a + n >= 10 * MS && !drive.power_good);
        repeat (200 * MS) @(negedge clk);
        chk("cord", PSS_LED_YELLOW, drive.led);
        @(posedge clk);
        sns.peer_ac <= 1'b0;
        repeat (50) @(negedge clk);
        chk("dark", PSS_LED_DARK, drive.led);
        @(posedge clk);
        sns.ac_ok <= 1'b1;
        till(SB, 1'b1, 1498 * MS);
        a = n;
        chk("sb", 1, drive.standby_rail_en);
        till(MN, 1'b1, 1000 * MS);
        chk("sb main", 1, n >= 50 * MS && n <= 998 * MS);
        till(PG, 1'b1, 2000 * MS);
        chk("all", 1, a + n <= 1200 * MS && drive.power_good);
        $display("t_acloss done");
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_standby;
        t_on;
        t_off;
        t_modes;
        t_crit;
        t_acloss;
        finish_test;
    end
endmodule
